// >>> lobr_bias_dec.sv
`timescale 1ns/10ps
module lobr_bias_dec (
   input  wire logic   clk_in,
   input  wire logic   srst_in,
   lobr_bias_if.dec_side bias
);
   logic [5:0] level_d;
   logic [5:0] level_q;

   // decodes the next field value so the level moves on the write edge
   always_comb begin
      level_d = lobr_pkg::lobr_bias_decode(bias.sel_d);
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         level_q <= lobr_pkg::LVL_X100;
      end else begin
         level_q <= level_d;
      end
   end

   assign bias.level = level_q;

   a_level_onehot: assert property (@(posedge clk_in) disable iff (srst_in)
      $onehot(level_q))
      else $error("bias level not one-hot");
endmodule

// >>> lobr_bias_if.sv
`timescale 1ns/10ps
interface lobr_bias_if;
   logic [2:0] sel_d;
   logic [5:0] level;
   modport reg_side (output sel_d, input level);
   modport dec_side (input sel_d, output level);
endinterface

// >>> lobr_pkg.sv
package lobr_pkg;
   localparam int          ADDR_W       = 10;
   localparam int          DATA_W       = 32;
   localparam int          BIAS_W       = 3;
   localparam int          LEVEL_W      = 6;

   // register indices; byte address is four times the index
   localparam logic [7:0]  STAGE_IDX    = 8'h5e;
   localparam logic [7:0]  AMP_BIAS_IDX = 8'hac;
   localparam logic [7:0]  DRV_BIAS_IDX = 8'hbb;

   localparam logic [7:0]  STAGE_RST    = 8'h00;
   localparam logic [2:0]  BIAS_RST     = 3'h0;

   // stage control bit positions
   localparam int          R_FIRST_BIT  = 0;
   localparam int          R_MID_BIT    = 1;
   localparam int          R_FINAL_BIT  = 2;
   localparam int          R_REL_BIT    = 3;
   localparam int          L_FIRST_BIT  = 4;
   localparam int          L_MID_BIT    = 5;
   localparam int          L_FINAL_BIT  = 6;
   localparam int          L_REL_BIT    = 7;

   // bias field low bit positions
   localparam int          AMP_LSB      = 4;
   localparam int          DRV_LSB      = 0;

   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // one-hot bias level, multiple of normal bias
   localparam logic [5:0]  LVL_X033     = 6'h01;
   localparam logic [5:0]  LVL_X050     = 6'h02;
   localparam logic [5:0]  LVL_X075     = 6'h04;
   localparam logic [5:0]  LVL_X100     = 6'h08;
   localparam logic [5:0]  LVL_X150     = 6'h10;
   localparam logic [5:0]  LVL_X200     = 6'h20;

   typedef enum logic {
      LOBR_IDLE = 1'b0,
      LOBR_ACK  = 1'b1
   } lobr_bus_state_type;

   function automatic logic [5:0] lobr_bias_decode(input logic [2:0] sel);
      logic [5:0] lvl;
      lvl = LVL_X100;
      case (sel)
         3'h1:    lvl = LVL_X150;
         3'h2:    lvl = LVL_X075;
         3'h3:    lvl = LVL_X050;
         3'h4:    lvl = LVL_X033;
         3'h7:    lvl = LVL_X200;
         default: lvl = LVL_X100;
      endcase
      return lvl;
   endfunction

   // unaligned byte addresses never hit a register
   function automatic logic lobr_hit(input logic [9:0] addr,
                                     input logic [7:0] idx);
      return (addr[9:2] == idx) && (addr[1:0] == 2'h0);
   endfunction
endpackage

// >>> lobr_regs.sv
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/10ps
// Function
// - left input stage enable, bit 4
// - left intermediate stage enable, bit 5
// - left final stage enable, bit 6
// - left short released by bit 7
// - right input stage enable, bit 0
// - right intermediate stage enable, bit 1
// - right final stage enable, bit 2
// - right short released by bit 3
// - amplifier bias field bits 6:4 decode
// - driver bias field bits 2:0, same decode
module lobr_regs (
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   input  wire logic [9:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   output logic      [1:0]  avs_response_out,
   output logic             left_line_first_stage_en_out,
   output logic             left_line_middle_stage_en_out,
   output logic             left_line_final_stage_en_out,
   output logic             left_line_short_release_out,
   output logic             right_line_first_stage_en_out,
   output logic             right_line_middle_stage_en_out,
   output logic             right_line_final_stage_en_out,
   output logic             right_line_short_release_out,
   output logic      [2:0]  output_amplifier_bias_sel_out,
   output logic      [2:0]  output_driver_bias_sel_out,
   output logic      [5:0]  output_amplifier_bias_level_out,
   output logic      [5:0]  output_driver_bias_level_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);

   lobr_pkg::lobr_bus_state_type state_d;
   lobr_pkg::lobr_bus_state_type state_q;
   logic        wait_d;
   logic        wait_q;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic [1:0]  resp_d;
   logic [1:0]  resp_q;

   logic [7:0]  stage_d;
   logic [7:0]  stage_q;
   logic [2:0]  amp_sel_d;
   logic [2:0]  amp_sel_q;
   logic [2:0]  drv_sel_d;
   logic [2:0]  drv_sel_q;

   logic        hit_stage;
   logic        hit_amp;
   logic        hit_drv;
   logic        hit_any;
   logic        req;
   logic        wr_take;
   logic        wr_lane0;
   logic        wr_stage;
   logic        wr_amp;
   logic        wr_drv;
   logic [7:0]  wb;

   lobr_bias_if amp_if ();
   lobr_bias_if drv_if ();

   assign hit_stage = lobr_pkg::lobr_hit(avs_address_in, lobr_pkg::STAGE_IDX);
   assign hit_amp = lobr_pkg::lobr_hit(avs_address_in,
                                       lobr_pkg::AMP_BIAS_IDX);
   assign hit_drv = lobr_pkg::lobr_hit(avs_address_in,
                                       lobr_pkg::DRV_BIAS_IDX);
   assign hit_any  = hit_stage | hit_amp | hit_drv;
   assign req      = avs_read_in | avs_write_in;
   assign wb       = avs_writedata_in[7:0];
   // a write lands on the edge where the master sees waitrequest low
   assign wr_take  = (state_q == lobr_pkg::LOBR_ACK) & avs_write_in;
   // all fields sit in byte lane 0; other lanes are ignored
   assign wr_lane0 = wr_take & avs_byteenable_in[0];
   assign wr_stage = wr_lane0 & hit_stage;
   assign wr_amp   = wr_lane0 & hit_amp;
   assign wr_drv   = wr_lane0 & hit_drv;

   // bus slave: one wait cycle, then one cycle of waitrequest low
   always_comb begin
      state_d = lobr_pkg::LOBR_IDLE;
      wait_d  = 1'b1;
      rdata_d = rdata_q;
      resp_d  = resp_q;
      case (state_q)
         lobr_pkg::LOBR_IDLE: begin
            if (req) begin
               state_d = lobr_pkg::LOBR_ACK;
               wait_d  = 1'b0;
               resp_d  = hit_any ? lobr_pkg::RESP_OKAY
                                 : lobr_pkg::RESP_SLVERR;
               rdata_d = 32'h0000_0000;
               if (avs_read_in && hit_stage) begin
                  rdata_d[7:0] = stage_q;
               end
               if (avs_read_in && hit_amp) begin
                  rdata_d[lobr_pkg::AMP_LSB +: 3] = amp_sel_q;
               end
               if (avs_read_in && hit_drv) begin
                  rdata_d[lobr_pkg::DRV_LSB +: 3] = drv_sel_q;
               end
            end
         end
         lobr_pkg::LOBR_ACK: begin
            state_d = lobr_pkg::LOBR_IDLE;
            wait_d  = 1'b1;
         end
         default: begin
            state_d = lobr_pkg::LOBR_IDLE;
            wait_d  = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state_q <= lobr_pkg::LOBR_IDLE;
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
         resp_q  <= lobr_pkg::RESP_OKAY;
      end else begin
         state_q <= state_d;
         wait_q  <= wait_d;
         rdata_q <= rdata_d;
         resp_q  <= resp_d;
      end
   end

   // field storage; the enable order is left to software, nothing here
   // interlocks the stages so any sequence can be forced for bring-up
   always_comb begin
      stage_d   = stage_q;
      amp_sel_d = amp_sel_q;
      drv_sel_d = drv_sel_q;
      if (wr_stage) begin
         stage_d = wb;
      end
      if (wr_amp) begin
         amp_sel_d = wb[lobr_pkg::AMP_LSB +: 3];
      end
      if (wr_drv) begin
         drv_sel_d = wb[lobr_pkg::DRV_LSB +: 3];
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         stage_q   <= lobr_pkg::STAGE_RST;
         amp_sel_q <= lobr_pkg::BIAS_RST;
         drv_sel_q <= lobr_pkg::BIAS_RST;
      end else begin
         stage_q   <= stage_d;
         amp_sel_q <= amp_sel_d;
         drv_sel_q <= drv_sel_d;
      end
   end

   // decoders see the next value, so levels follow on the write edge
   assign amp_if.sel_d = srst_in ? lobr_pkg::BIAS_RST : amp_sel_d;
   assign drv_if.sel_d = srst_in ? lobr_pkg::BIAS_RST : drv_sel_d;

   lobr_bias_dec u_amp_dec (
      .clk_in  (clk_in),
      .srst_in (srst_in),
      .bias    (amp_if.dec_side)
   );

   lobr_bias_dec u_drv_dec (
      .clk_in  (clk_in),
      .srst_in (srst_in),
      .bias    (drv_if.dec_side)
   );

   assign avs_readdata_out    = rdata_q;
   assign avs_waitrequest_out = wait_q;
   assign avs_response_out    = resp_q;

   // short release is a plain stored bit: 0 keeps the output shorted
   assign left_line_first_stage_en_out   = stage_q[lobr_pkg::L_FIRST_BIT];
   assign left_line_middle_stage_en_out  = stage_q[lobr_pkg::L_MID_BIT];
   assign left_line_final_stage_en_out   = stage_q[lobr_pkg::L_FINAL_BIT];
   assign left_line_short_release_out    = stage_q[lobr_pkg::L_REL_BIT];
   assign right_line_first_stage_en_out  = stage_q[lobr_pkg::R_FIRST_BIT];
   assign right_line_middle_stage_en_out = stage_q[lobr_pkg::R_MID_BIT];
   assign right_line_final_stage_en_out  = stage_q[lobr_pkg::R_FINAL_BIT];
   assign right_line_short_release_out   = stage_q[lobr_pkg::R_REL_BIT];
   assign output_amplifier_bias_sel_out   = amp_sel_q;
   assign output_driver_bias_sel_out      = drv_sel_q;
   assign output_amplifier_bias_level_out = amp_if.level;
   assign output_driver_bias_level_out    = drv_if.level;

   property p_bit_follow(logic ena, logic want, logic got);
      (ena && want |=> got) and (ena && !want |=> !got);
   endproperty

   a_left_first: assert property (
      p_bit_follow(wr_stage, wb[lobr_pkg::L_FIRST_BIT],
                   left_line_first_stage_en_out))
      else $error("left first stage enable did not follow write");
   a_left_middle: assert property (
      p_bit_follow(wr_stage, wb[lobr_pkg::L_MID_BIT],
                   left_line_middle_stage_en_out))
      else $error("left middle stage enable did not follow write");
   a_left_final: assert property (
      p_bit_follow(wr_stage, wb[lobr_pkg::L_FINAL_BIT],
                   left_line_final_stage_en_out))
      else $error("left final stage enable did not follow write");
   a_left_short: assert property (
      p_bit_follow(wr_stage, wb[lobr_pkg::L_REL_BIT],
                   left_line_short_release_out))
      else $error("left short release did not follow write");
   a_right_first: assert property (
      p_bit_follow(wr_stage, wb[lobr_pkg::R_FIRST_BIT],
                   right_line_first_stage_en_out))
      else $error("right first stage enable did not follow write");
   a_right_middle: assert property (
      p_bit_follow(wr_stage, wb[lobr_pkg::R_MID_BIT],
                   right_line_middle_stage_en_out))
      else $error("right middle stage enable did not follow write");
   a_right_final: assert property (
      p_bit_follow(wr_stage, wb[lobr_pkg::R_FINAL_BIT],
                   right_line_final_stage_en_out))
      else $error("right final stage enable did not follow write");
   a_right_short: assert property (
      p_bit_follow(wr_stage, wb[lobr_pkg::R_REL_BIT],
                   right_line_short_release_out))
      else $error("right short release did not follow write");

   a_reset_shorted: assert property (
      disable iff (1'b0)
      srst_in |=> (stage_q == lobr_pkg::STAGE_RST) && wait_q)
      else $error("stage register not cleared by reset");

   a_stage_holds: assert property (
      !wr_stage |=> $stable(stage_q))
      else $error("stage register changed without a write");

   a_amp_level: assert property (
      output_amplifier_bias_level_out
         == lobr_pkg::lobr_bias_decode(amp_sel_q))
      else $error("amplifier bias level out of step with field");
   a_drv_level: assert property (
      output_driver_bias_level_out
         == lobr_pkg::lobr_bias_decode(drv_sel_q))
      else $error("driver bias level out of step with field");

   a_drv_indep: assert property (
      wr_drv && !wr_amp |=> $stable(amp_sel_q))
      else $error("driver bias write disturbed amplifier bias");

   a_stage_readback: assert property (
      (state_q == lobr_pkg::LOBR_IDLE) && avs_read_in && hit_stage
      |=> !avs_waitrequest_out && (avs_readdata_out[7:0] == stage_q)
          && (avs_readdata_out[31:8] == 24'h00_0000))
      else $error("stage register read back wrong");

   a_bus_answer: assert property (
      (state_q == lobr_pkg::LOBR_IDLE) && req
      |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
      else $error("waitrequest not low for exactly one cycle");

   a_bus_unmapped: assert property (
      (state_q == lobr_pkg::LOBR_IDLE) && req && !hit_any
      |=> avs_response_out == lobr_pkg::RESP_SLVERR)
      else $error("unmapped access not answered with slave error");

   a_mapped_okay: assert property (
      (state_q == lobr_pkg::LOBR_IDLE) && req && hit_any
      |=> avs_response_out == lobr_pkg::RESP_OKAY)
      else $error("mapped access not answered okay");

   a_no_answer: assert property (
      (state_q == lobr_pkg::LOBR_IDLE) && !req |=> avs_waitrequest_out)
      else $error("waitrequest dropped without a request");

   a_amp_write: assert property (
      wr_amp |=> amp_sel_q == $past(wb[lobr_pkg::AMP_LSB +: 3]))
      else $error("amplifier bias field did not take the write");

   a_drv_write: assert property (
      wr_drv |=> drv_sel_q == $past(wb[lobr_pkg::DRV_LSB +: 3]))
      else $error("driver bias field did not take the write");

   a_amp_holds: assert property (
      !wr_amp |=> $stable(amp_sel_q))
      else $error("amplifier bias field changed without a write");

   a_drv_holds: assert property (
      !wr_drv |=> $stable(drv_sel_q))
      else $error("driver bias field changed without a write");

   // reset must leave both bias paths at normal bias, levels included
   a_bias_reset: assert property (
      disable iff (1'b0)
      srst_in |=> (amp_sel_q == lobr_pkg::BIAS_RST)
                  && (drv_sel_q == lobr_pkg::BIAS_RST)
                  && (output_amplifier_bias_level_out == lobr_pkg::LVL_X100)
                  && (output_driver_bias_level_out == lobr_pkg::LVL_X100))
      else $error("bias fields not at normal after reset");

   // unused read bits stay zero so software can compare whole words
   a_amp_readback: assert property (
      (state_q == lobr_pkg::LOBR_IDLE) && avs_read_in && hit_amp
      |=> avs_readdata_out == (32'(amp_sel_q) << lobr_pkg::AMP_LSB))
      else $error("amplifier bias register read back wrong");

   a_drv_readback: assert property (
      (state_q == lobr_pkg::LOBR_IDLE) && avs_read_in && hit_drv
      |=> avs_readdata_out == (32'(drv_sel_q) << lobr_pkg::DRV_LSB))
      else $error("driver bias register read back wrong");

   a_unmapped_zero: assert property (
      (state_q == lobr_pkg::LOBR_IDLE) && avs_read_in && !hit_any
      |=> avs_readdata_out == 32'h0000_0000)
      else $error("unmapped read returned data");

   // a write that misses byte lane 0 must leave every field alone
   a_byte_lane: assert property (
      wr_take && !avs_byteenable_in[0]
      |=> $stable(stage_q) && $stable(amp_sel_q) && $stable(drv_sel_q))
      else $error("write without lane 0 changed a field");

   // reads have no side effects on any field
   a_read_silent: assert property (
      (state_q == lobr_pkg::LOBR_ACK) && avs_read_in
      |=> $stable(stage_q) && $stable(amp_sel_q) && $stable(drv_sel_q))
      else $error("read changed a field");

   c_full_enable: cover property (
      wr_stage && (wb == 8'hff));
   c_drv_raised: cover property (
      wr_drv ##1 (output_driver_bias_level_out == lobr_pkg::LVL_X200));
   c_amp_read: cover property (
      (state_q == lobr_pkg::LOBR_IDLE) && avs_read_in && hit_amp);
   c_back_to_back: cover property (
      wr_take ##1 req ##1 !avs_waitrequest_out);
   c_unmapped: cover property (
      (state_q == lobr_pkg::LOBR_IDLE) && req && !hit_any);
endmodule

// >>> lobr_regs_tb.sv
`timescale 1ns/10ps
module lobr_regs_tb;
   typedef struct {
      logic        is_rd;
      logic [31:0] data;
      logic [1:0]  resp;
      logic [25:0] outs;
   } lobr_note_type;

   logic          clk_in;
   logic          srst_in;
   logic [9:0]    avs_address_in;
   logic          avs_read_in;
   logic          avs_write_in;
   logic [31:0]   avs_writedata_in;
   logic [3:0]    avs_byteenable_in;
   logic [31:0]   avs_readdata_out;
   logic          avs_waitrequest_out;
   logic [1:0]    avs_response_out;
   wire  [7:0]    stage_out;
   logic [2:0]    amp_sel_out;
   logic [2:0]    drv_sel_out;
   logic [5:0]    amp_lvl_out;
   logic [5:0]    drv_lvl_out;
   logic [25:0]   obs_outs;
   int            err_count;
   int            num_checks;
   lobr_note_type notes[$];
   logic [7:0]    sh_stage;
   logic [2:0]    sh_amp;
   logic [2:0]    sh_drv;
   logic [31:0]   rng_q;
   logic          chk_out_q = 1'b0;
   logic [25:0]   exp_outs_q;
   logic [9:0]    addr_tab[5] = '{10'h178, 10'h2b0, 10'h2ec, 10'h17a, 10'h004};

   lobr_regs uut (
      .clk_in                          (clk_in),
      .srst_in                         (srst_in),
      .avs_address_in                  (avs_address_in),
      .avs_read_in                     (avs_read_in),
      .avs_write_in                    (avs_write_in),
      .avs_writedata_in                (avs_writedata_in),
      .avs_byteenable_in               (avs_byteenable_in),
      .avs_readdata_out                (avs_readdata_out),
      .avs_waitrequest_out             (avs_waitrequest_out),
      .avs_response_out                (avs_response_out),
      .left_line_first_stage_en_out    (stage_out[4]),
      .left_line_middle_stage_en_out   (stage_out[5]),
      .left_line_final_stage_en_out    (stage_out[6]),
      .left_line_short_release_out     (stage_out[7]),
      .right_line_first_stage_en_out   (stage_out[0]),
      .right_line_middle_stage_en_out  (stage_out[1]),
      .right_line_final_stage_en_out   (stage_out[2]),
      .right_line_short_release_out    (stage_out[3]),
      .output_amplifier_bias_sel_out   (amp_sel_out),
      .output_driver_bias_sel_out      (drv_sel_out),
      .output_amplifier_bias_level_out (amp_lvl_out),
      .output_driver_bias_level_out    (drv_lvl_out)
   );

   assign obs_outs = {stage_out, amp_sel_out, drv_sel_out,
                      amp_lvl_out, drv_lvl_out};

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   function automatic logic [5:0] lvl(input logic [2:0] s);
      case (s)
         3'h1:    return lobr_pkg::LVL_X150;
         3'h2:    return lobr_pkg::LVL_X075;
         3'h3:    return lobr_pkg::LVL_X050;
         3'h4:    return lobr_pkg::LVL_X033;
         3'h7:    return lobr_pkg::LVL_X200;
         default: return lobr_pkg::LVL_X100;
      endcase
   endfunction

   function automatic logic [31:0] rnd();
      rng_q = rng_q ^ (rng_q << 13);
      rng_q = rng_q ^ (rng_q >> 17);
      rng_q = rng_q ^ (rng_q << 5);
      return rng_q;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what,
                  got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // request stays up on return so a following call runs back to back
   task automatic bus(input logic wr, input logic [9:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      lobr_note_type n;
      logic          hit;
      int            k;
      hit = (a[1:0] == 2'h0) && (a[9:2] == lobr_pkg::STAGE_IDX ||
            a[9:2] == lobr_pkg::AMP_BIAS_IDX ||
            a[9:2] == lobr_pkg::DRV_BIAS_IDX);
      if (wr && hit && be[0]) begin
         if (a[9:2] == lobr_pkg::STAGE_IDX) sh_stage = d[7:0];
         if (a[9:2] == lobr_pkg::AMP_BIAS_IDX) sh_amp = d[6:4];
         if (a[9:2] == lobr_pkg::DRV_BIAS_IDX) sh_drv = d[2:0];
      end
      n.is_rd = !wr;
      n.resp = hit ? lobr_pkg::RESP_OKAY : lobr_pkg::RESP_SLVERR;
      n.data = 32'h0000_0000;
      if (hit && a[9:2] == lobr_pkg::STAGE_IDX) n.data[7:0] = sh_stage;
      if (hit && a[9:2] == lobr_pkg::AMP_BIAS_IDX) n.data[6:4] = sh_amp;
      if (hit && a[9:2] == lobr_pkg::DRV_BIAS_IDX) n.data[2:0] = sh_drv;
      n.outs = {sh_stage, sh_amp, sh_drv, lvl(sh_amp), lvl(sh_drv)};
      notes.push_back(n);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_byteenable_in <= be;
      avs_read_in <= !wr;
      avs_write_in <= wr;
      k = 0;
      do begin
         @(posedge clk_in);
         k++;
      end while (avs_waitrequest_out !== 1'b0 && k < 50);
      if (k >= 50) begin
         err_count++;
         $display("Error at %0t: bus answer missing", $time);
         tally_and_finish();
      end
   endtask

   task automatic idle(input int n);
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      repeat (n) @(posedge clk_in);
   endtask

   task automatic do_reset();
      srst_in <= 1'b1;
      repeat (20) @(posedge clk_in);
      srst_in <= 1'b0;
      sh_stage = 8'h00;
      sh_amp = 3'h0;
      sh_drv = 3'h0;
      @(posedge clk_in);
   endtask

   // results are judged one edge after they stand on the outputs
   always @(posedge clk_in) begin
      lobr_note_type n;
      if (chk_out_q) begin
         chk({6'h00, obs_outs}, {6'h00, exp_outs_q}, "outputs");
      end
      chk_out_q = 1'b0;
      if (!srst_in && avs_waitrequest_out === 1'b0) begin
         if (notes.size() == 0) begin
            chk(32'h0000_0001, 32'h0000_0000, "unexpected answer");
         end else begin
            n = notes.pop_front();
            chk({30'h0, avs_response_out}, {30'h0, n.resp},
                "response");
            if (n.is_rd) chk(avs_readdata_out, n.data, "readdata");
            exp_outs_q = n.outs;
            chk_out_q = 1'b1;
         end
      end
   end

   initial begin
      err_count = 0;
      num_checks = 0;
      rng_q = 32'h0001_65e3;
      srst_in = 1'b1;
      avs_address_in = 10'h000;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_writedata_in = 32'h0000_0000;
      avs_byteenable_in = 4'h0;
      do_reset();
      foreach (addr_tab[i]) bus(1'b0, addr_tab[i], 0, 4'hf);
      idle(1);
      $display("test reset_values done");
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 10'h178, 32'hffff_ff00 | (1 << i), 4'h1);
         bus(1'b0, 10'h178, 32'h0000_0000, 4'hf);
      end
      idle(1);
      $display("test stage_bits done");
      bus(1'b1, 10'h178, 32'h0000_0000, 4'h1);
      for (int ch = 0; ch < 2; ch++) begin
         bus(1'b1, 10'h178, {24'h0, sh_stage | (8'h01 << 4 * ch)}, 4'h1);
         idle(2000);
         bus(1'b1, 10'h178, {24'h0, sh_stage | (8'h02 << 4 * ch)}, 4'h1);
         bus(1'b1, 10'h178, {24'h0, sh_stage | (8'h04 << 4 * ch)}, 4'h1);
         bus(1'b1, 10'h178, {24'h0, sh_stage | (8'h08 << 4 * ch)}, 4'h1);
         bus(1'b0, 10'h178, 32'h0000_0000, 4'hf);
         idle(1);
      end
      $display("test enable_order done");
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, 10'h2ec, 32'hffff_fff8 | c, 4'h1);
         bus(1'b0, 10'h2ec, 32'h0000_0000, 4'hf);
      end
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, 10'h2b0, 32'hffff_ff8f | (c << 4), 4'h1);
         bus(1'b0, 10'h2b0, 32'h0000_0000, 4'hf);
      end
      idle(1);
      $display("test bias_codes done");
      bus(1'b1, 10'h000, 32'h0000_00ff, 4'hf);
      bus(1'b1, 10'h179, 32'h0000_0000, 4'hf);
      bus(1'b1, 10'h2b1, 32'h0000_0000, 4'hf);
      bus(1'b1, 10'h178, 32'h0000_0000, 4'he);
      bus(1'b0, 10'h3fc, 32'h0000_0000, 4'hf);
      bus(1'b0, 10'h178, 32'h0000_0000, 4'hf);
      idle(1);
      $display("test refusals done");
      for (int i = 0; i < 60; i++) begin
         bus(1'(rnd() % 2), addr_tab[rnd() % 5], rnd(), 4'(rnd()));
         if (rnd() % 4 == 0) idle(1 + rnd() % 3);
      end
      idle(1);
      $display("test random done");
      bus(1'b1, 10'h178, 32'h0000_00ff, 4'hf);
      bus(1'b1, 10'h2b0, 32'h0000_0070, 4'hf);
      idle(3);
      do_reset();
      foreach (addr_tab[i]) bus(1'b0, addr_tab[i], 0, 4'hf);
      idle(3);
      $display("test second_reset done");
      chk(notes.size(), 0, "pending notes");
      tally_and_finish();
   end
endmodule
